// *** rtl/gpcp_defines.vh ***
// register map, field positions and reset values for the gpio change block
`ifndef GPCP_DEFINES_VH
`define GPCP_DEFINES_VH
`define GPCP_ADDR_W 8
`define GPCP_OFS_FIRST_PORT 8'h06
`define GPCP_OFS_SECOND_PORT 8'h07
`define GPCP_OFS_OPTION 8'h81
`define GPCP_OFS_FIRST_DIR 8'h86
`define GPCP_OFS_SECOND_DIR 8'h87
`define GPCP_OFS_INT_CTRL 8'h8B
`define GPCP_OFS_TIMER_CTRL 8'h10
`define GPCP_OFS_PERIPH 8'h90
`define GPCP_OFS_STATUS 8'h91
`define GPCP_RST_OPTION 8'hFF
`define GPCP_RST_DIR 8'hFF
`define GPCP_RST_INT_CTRL 8'h00
`define GPCP_RST_TIMER_CTRL 8'h00
`define GPCP_BIT_PULLUP_N 7
`define GPCP_BIT_EDGE_SEL 6
`define GPCP_BIT_GIE 7
`define GPCP_BIT_EXT_EN 4
`define GPCP_BIT_CHG_EN 3
`define GPCP_BIT_EXT_FLAG 1
`define GPCP_BIT_CHG_FLAG 0
`define GPCP_BIT_AUX_OSC 3
`endif

// *** rtl/gpcp_ports.v ***
// two general-purpose ports with change detect, external edge interrupt and overrides
//
// Our own choice: strobed register access.
`timescale 1ns/1ns
`default_nettype none
`include "gpcp_defines.vh"
// Functional notes
// [R1] first port pin is input when direction bit is 1, driven from latch at 0
// [R2] second port direction bits behave the same way
// [R3] first port has eight pins with an eight bit direction register
// [R4] clearing option bit 7 enables all first port pull-ups
// [R5] pull-up forced off on any first port pin set as output
// [R6] pull-ups disabled after reset
// [R7] only upper four first port inputs take part in change detect
// [R8] inputs compared against copy latched at last first port access
// [R9] the four mismatches are ORed into change flag, bit 0 of interrupt control
// [R10] change condition raises a wake request usable during sleep
// [R11] any first port access refreshes the copy; software does it before clearing
// [R12] persisting mismatch keeps setting the flag over a software clear
// [R13] software should not poll the first port during change detect
// [R14] option bit 6 selects active edge of the external interrupt pin
// [R15] second port has eight pins each with a direction bit
// [R16] enabled peripherals override second port direction to output or input
// [R17] software avoids read-modify-write on second direction under override
// [R18] aux oscillator enable, timer control bit 3, takes second port pins 1:0
// [R19] aux oscillator enable stays in force during sleep
// [R20] software waits for oscillator start-up after enabling it
// [R21] any reset sets both direction registers to all ones
// [R22] change flag raises request only with its enable and global enable set
// [R23] selected edge on external pin sets a sticky flag until software clears it
module gpcp_ports (
   input wire CLK,
   input wire RST,
   input wire [7:0] ADDR,
   input wire [7:0] WDATA,
   input wire WR,
   input wire RD,
   output reg [7:0] RDATA,
   input wire [7:0] FIRST_IN,
   output reg [7:0] FIRST_OUT,
   output reg [7:0] FIRST_OE_N,
   output reg [7:0] FIRST_PULLUP,
   input wire [7:0] SECOND_IN,
   output reg [7:0] SECOND_OUT,
   output reg [7:0] SECOND_OE_N,
   input wire [7:0] PERIPH_EN,
   input wire [7:0] PERIPH_DIR,
   input wire [7:0] PERIPH_OUT,
   input wire SLEEP,
   output reg INT_REQ,
   output reg WAKE_REQ,
   output reg AUX_OSC_ENABLE
);
   reg [7:0] first_sync1, first_sync2, second_sync1, second_sync2;
   reg [7:0] first_latch, second_latch, first_dir, second_dir;
   reg [7:0] option_config, int_ctrl, timer_ctrl;
   reg [3:0] change_copy;
   reg ext_prev;
   wire [7:0] int_ctrl_rd;
   wire [7:0] eff_dir;
   wire [7:0] eff_out;
   wire first_access;
   wire [3:0] mismatch;
   wire change_hit;
   wire ext_edge;
   wire wr_int;
   wire next_chg_flag;
   wire next_ext_flag;

   always @(posedge CLK) begin
      first_sync1 <= FIRST_IN;
      first_sync2 <= first_sync1;
      second_sync1 <= SECOND_IN;
      second_sync2 <= second_sync1;
   end

   assign first_access = (RD || WR) && (ADDR == `GPCP_OFS_FIRST_PORT);
   // [R7] [R8] inputs against copy
   assign mismatch = (first_sync2[7:4] ^ change_copy) & first_dir[7:4];
   // [R9] or of mismatches
   assign change_hit = |mismatch;
   // [R14] edge select
   assign ext_edge = option_config[`GPCP_BIT_EDGE_SEL] ? (first_sync2[0] && !ext_prev)
                                                       : (!first_sync2[0] && ext_prev);
   assign wr_int = WR && (ADDR == `GPCP_OFS_INT_CTRL);
   // [R12] mismatch set beats clear
   assign next_chg_flag = change_hit ||
      (wr_int ? WDATA[`GPCP_BIT_CHG_FLAG] : int_ctrl[`GPCP_BIT_CHG_FLAG]);
   // [R23] sticky edge flag, set wins
   assign next_ext_flag = ext_edge ||
      (wr_int ? WDATA[`GPCP_BIT_EXT_FLAG] : int_ctrl[`GPCP_BIT_EXT_FLAG]);
   assign int_ctrl_rd = int_ctrl;

   // [R16] peripheral direction override
   genvar i;
   generate
      for (i = 0; i < 8; i = i + 1) begin : g_sec
         if (i < 2) begin : g_osc
            // [R18] oscillator takes pins 1:0 as inputs
            assign eff_dir[i] = timer_ctrl[`GPCP_BIT_AUX_OSC] ? 1'b1
                              : (PERIPH_EN[i] ? PERIPH_DIR[i] : second_dir[i]);
         end else begin : g_plain
            assign eff_dir[i] = PERIPH_EN[i] ? PERIPH_DIR[i] : second_dir[i];
         end
         assign eff_out[i] = PERIPH_EN[i] ? PERIPH_OUT[i] : second_latch[i];
      end
   endgenerate

   always @(posedge CLK) begin
      if (RST) begin
         // [R21] all pins inputs on reset
         first_dir <= `GPCP_RST_DIR;
         second_dir <= `GPCP_RST_DIR;
         // [R6] pull-ups off
         option_config <= `GPCP_RST_OPTION;
         int_ctrl <= `GPCP_RST_INT_CTRL;
         timer_ctrl <= `GPCP_RST_TIMER_CTRL;
         first_latch <= 8'h00;
         second_latch <= 8'h00;
         change_copy <= 4'h0;
         ext_prev <= 1'b0;
      end else begin
         ext_prev <= first_sync2[0];
         // [R11] access refreshes copy
         if (first_access) begin
            change_copy <= first_sync2[7:4];
         end
         if (WR) begin
            case (ADDR)
               `GPCP_OFS_FIRST_PORT: first_latch <= WDATA;
               `GPCP_OFS_SECOND_PORT: second_latch <= WDATA;
               `GPCP_OFS_OPTION: option_config <= WDATA;
               `GPCP_OFS_FIRST_DIR: first_dir <= WDATA;
               `GPCP_OFS_SECOND_DIR: second_dir <= WDATA;
               `GPCP_OFS_TIMER_CTRL: timer_ctrl <= {2'b00, WDATA[5:0]};
               default: ;
            endcase
         end
         if (wr_int) begin
            int_ctrl[7:2] <= WDATA[7:2];
         end
         // [R9] change flag in bit 0
         int_ctrl[`GPCP_BIT_CHG_FLAG] <= next_chg_flag;
         int_ctrl[`GPCP_BIT_EXT_FLAG] <= next_ext_flag;
      end
   end

   always @(posedge CLK) begin
      if (RST) begin
         RDATA <= 8'h00;
         FIRST_OUT <= 8'h00;
         FIRST_OE_N <= 8'hFF;
         FIRST_PULLUP <= 8'h00;
         SECOND_OUT <= 8'h00;
         SECOND_OE_N <= 8'hFF;
         INT_REQ <= 1'b0;
         WAKE_REQ <= 1'b0;
         AUX_OSC_ENABLE <= 1'b0;
      end else begin
         // [R1] [R3] first port drive
         FIRST_OUT <= first_latch;
         FIRST_OE_N <= first_dir;
         // [R4] [R5] pull-ups only on inputs
         FIRST_PULLUP <= option_config[`GPCP_BIT_PULLUP_N] ? 8'h00 : first_dir;
         // [R2] [R15] second port drive
         SECOND_OUT <= eff_out;
         SECOND_OE_N <= eff_dir;
         // [R22] gated request
         INT_REQ <= int_ctrl[`GPCP_BIT_GIE] &&
            ((int_ctrl[`GPCP_BIT_CHG_EN] && int_ctrl[`GPCP_BIT_CHG_FLAG]) ||
             (int_ctrl[`GPCP_BIT_EXT_EN] && int_ctrl[`GPCP_BIT_EXT_FLAG]));
         // [R10] wake from sleep on change
         WAKE_REQ <= SLEEP && int_ctrl[`GPCP_BIT_CHG_EN] && int_ctrl[`GPCP_BIT_CHG_FLAG];
         // [R19] enable independent of sleep
         AUX_OSC_ENABLE <= timer_ctrl[`GPCP_BIT_AUX_OSC];
         RDATA <= 8'h00;
         if (RD) begin
            case (ADDR)
               `GPCP_OFS_FIRST_PORT: RDATA <= first_sync2;
               `GPCP_OFS_SECOND_PORT: RDATA <= second_sync2;
               `GPCP_OFS_OPTION: RDATA <= option_config;
               `GPCP_OFS_FIRST_DIR: RDATA <= first_dir;
               `GPCP_OFS_SECOND_DIR: RDATA <= second_dir;
               `GPCP_OFS_INT_CTRL: RDATA <= int_ctrl_rd;
               `GPCP_OFS_TIMER_CTRL: RDATA <= timer_ctrl;
               `GPCP_OFS_PERIPH: RDATA <= PERIPH_EN;
               `GPCP_OFS_STATUS: RDATA <= {4'h0, mismatch};
               default: RDATA <= 8'h00;
            endcase
         end
      end
   end
endmodule // gpcp_ports
`default_nettype wire

// *** tb/gpcp_chk.sv ***
// assertion checker for the gpio change block
`timescale 1ns/1ns
`default_nettype none
module gpcp_chk (
   input wire logic CLK,
   input wire logic RST,
   input wire logic [7:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic [7:0] FIRST_OUT,
   input wire logic [7:0] FIRST_OE_N,
   input wire logic [7:0] FIRST_PULLUP,
   input wire logic [7:0] SECOND_OE_N,
   input wire logic [7:0] PERIPH_EN,
   input wire logic [7:0] PERIPH_DIR,
   input wire logic SLEEP,
   input wire logic WAKE_REQ,
   input wire logic AUX_OSC_ENABLE
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);
   sequence s_wr(a);
      WR && ADDR == a;
   endsequence
   a_dir_follow: assert property (s_wr(8'h86) |-> ##2 FIRST_OE_N == $past(WDATA, 2))
      else $error("first direction not on pins");
   a_out_latch: assert property (s_wr(8'h06) |-> ##2 FIRST_OUT == $past(WDATA, 2))
      else $error("first latch not on pins");
   a_pull_out: assert property ((FIRST_PULLUP & ~FIRST_OE_N) == 8'h00)
      else $error("pull-up on driven pin");
   a_pull_all: assert property (FIRST_PULLUP == 8'h00 || FIRST_PULLUP == FIRST_OE_N)
      else $error("pull-ups not common");
   a_wake_sleep: assert property (WAKE_REQ |-> $past(SLEEP))
      else $error("wake outside sleep");
   a_osc_pins: assert property (AUX_OSC_ENABLE && $past(AUX_OSC_ENABLE) |-> SECOND_OE_N[1:0] == 2'b11)
      else $error("oscillator pins driven");
   a_periph_ovr: assert property ($stable(PERIPH_EN) && $stable(PERIPH_DIR)
      |-> ((SECOND_OE_N ^ PERIPH_DIR) & PERIPH_EN & 8'hFC) == 8'h00)
      else $error("peripheral direction lost");
   a_dir_reset: assert property ($fell(RST) |-> FIRST_OE_N == 8'hFF && SECOND_OE_N == 8'hFF)
      else $error("pins not inputs after reset");
endmodule // gpcp_chk
bind gpcp_ports gpcp_chk i_chk (.CLK, .RST, .ADDR, .WDATA, .WR, .FIRST_OUT, .FIRST_OE_N, .FIRST_PULLUP,
   .SECOND_OE_N, .PERIPH_EN, .PERIPH_DIR, .SLEEP, .WAKE_REQ, .AUX_OSC_ENABLE);
`default_nettype wire

// *** tb/gpcp_pins.sv ***
// pin level model of the circuitry outside both ports
`timescale 1ns/1ns
`default_nettype none
module gpcp_pins (
   input wire logic clk,
   input wire logic [7:0] f_out,
   input wire logic [7:0] f_oe_n,
   input wire logic [7:0] f_pu,
   input wire logic [7:0] s_out,
   input wire logic [7:0] s_oe_n,
   input wire logic [7:0] ev,
   input wire logic [7:0] ed,
   output logic [7:0] f_in,
   output logic [7:0] s_in
);
   logic [7:0] tog = 8'h55;
   // floating pin without pull-up wanders
   always @(posedge clk) tog <= ~tog;
   assign f_in = (~f_oe_n & f_out) | (f_oe_n & ed & ev) | (f_oe_n & ~ed & (f_pu | tog));
   assign s_in = (~s_oe_n & s_out) | (s_oe_n & ev);
endmodule // gpcp_pins
`default_nettype wire

// *** tb/tb.sv ***
// self-checking bench for the gpio change block
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic CLK = 0, RST = 1, WR = 0, RD = 0, SLEEP = 0;
   logic [7:0] ADDR = 0, WDATA = 0, PERIPH_EN = 0, PERIPH_DIR = 0, PERIPH_OUT = 8'h3C, ev = 8'h20, ed = 8'hFF;
   wire [7:0] RDATA, FIRST_IN, FIRST_OUT, FIRST_OE_N, FIRST_PULLUP, SECOND_IN, SECOND_OUT, SECOND_OE_N;
   wire INT_REQ, WAKE_REQ, AUX_OSC_ENABLE;
   int err_total = 0, n_tests = 0;
   always #4 CLK = ~CLK;
   gpcp_ports i_dut (.CLK, .RST, .ADDR, .WDATA, .WR, .RD, .RDATA, .FIRST_IN, .FIRST_OUT, .FIRST_OE_N, .FIRST_PULLUP,
      .SECOND_IN, .SECOND_OUT, .SECOND_OE_N, .PERIPH_EN, .PERIPH_DIR, .PERIPH_OUT, .SLEEP, .INT_REQ, .WAKE_REQ,
      .AUX_OSC_ENABLE);
   gpcp_pins i_pins (.clk(CLK), .f_out(FIRST_OUT), .f_oe_n(FIRST_OE_N), .f_pu(FIRST_PULLUP), .s_out(SECOND_OUT),
      .s_oe_n(SECOND_OE_N), .ev, .ed, .f_in(FIRST_IN), .s_in(SECOND_IN));
   task chk(string n, logic [7:0] e, logic [7:0] s);
      n_tests++;
      if (s !== e) begin
         err_total++;
         $display("BAD %s exp %h got %h", n, e, s);
      end
   endtask
   task wr(logic [7:0] a, logic [7:0] d);
      @(posedge CLK);
      ADDR <= a;
      WDATA <= d;
      WR <= 1;
      @(posedge CLK);
      WR <= 0;
   endtask
   task rd(logic [7:0] a, logic [7:0] e);
      @(posedge CLK);
      ADDR <= a;
      RD <= 1;
      @(posedge CLK);
      RD <= 0;
      #1 chk($sformatf("reg %h", a), e, RDATA);
   endtask
   task wt(int n);
      repeat (n) @(posedge CLK);
      #1;
   endtask
   task end_sim;
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      #20000;
      err_total++;
      end_sim;
   end
   initial begin
      repeat (20) @(posedge CLK);
      RST <= 0;
      rd(8'h06, 8'h20);
      wr(8'h8B, 8'h00);
      rd(8'h81, 8'hFF);
      rd(8'h86, 8'hFF);
      rd(8'h87, 8'hFF);
      rd(8'h8B, 8'h00);
      rd(8'h88, 8'h00);
      chk("pullup", 8'h00, FIRST_PULLUP);
      $display("test reset done");
      wr(8'h06, 8'hA5);
      wr(8'h86, 8'hF1);
      wt(4);
      chk("oe", 8'hF1, FIRST_OE_N);
      chk("out", 8'hA5, FIRST_OUT);
      rd(8'h06, 8'h24);
      $display("test drive done");
      // no polling while waiting for a change
      wr(8'h8B, 8'h98);
      SLEEP <= 1;
      ev[6] <= 1;
      wt(5);
      chk("int", 8'h01, {7'h0, INT_REQ});
      chk("wake", 8'h01, {7'h0, WAKE_REQ});
      wr(8'h8B, 8'h98);
      rd(8'h8B, 8'h99);
      rd(8'h06, 8'h64);
      wr(8'h8B, 8'h98);
      wr(8'h86, 8'h71);
      SLEEP <= 0;
      wt(5);
      rd(8'h8B, 8'h98);
      $display("test change done");
      ev[0] <= 1;
      wt(5);
      rd(8'h8B, 8'h9A);
      wr(8'h8B, 8'h98);
      wr(8'h81, 8'h3F);
      ev[0] <= 0;
      wt(5);
      rd(8'h8B, 8'h9A);
      chk("pullup", 8'h71, FIRST_PULLUP);
      ed <= 8'h0F;
      wt(4);
      rd(8'h06, 8'hF4);
      $display("test edge pullup done");
      wr(8'h87, 8'h0F);
      wt(2);
      chk("oe2", 8'h0F, SECOND_OE_N);
      PERIPH_EN <= 8'h0C;
      PERIPH_DIR <= 8'h04;
      wr(8'h10, 8'h08);
      SLEEP <= 1;
      // start-up wait before relying on oscillator
      wt(3);
      chk("oe2", 8'h07, SECOND_OE_N);
      chk("out2", 8'h0C, SECOND_OUT);
      rd(8'h07, 8'h08);
      chk("osc", 8'h01, {7'h0, AUX_OSC_ENABLE});
      rd(8'h10, 8'h08);
      $display("test second port done");
      end_sim;
   end
endmodule // tb
`default_nettype wire
